// ==== oag_core.sv ====
`timescale 1ns/1ps
// Operand address generator: takes a full instruction, fetches the
// tested byte when needed, then presents address and next PC.
module oag_core
  import oag_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RST_B,
  input wire logic I_START,
  input wire oag_req_t I_REQ,
  input wire logic [7:0] I_RD_DATA,
  input wire logic I_RD_VALID,
  output logic O_BUSY,
  output logic O_DONE,
  output logic O_RD_REQ,
  output logic [7:0] O_ADDR_HI,
  output logic [7:0] O_ADDR_LO,
  output logic [15:0] O_NEXT_PC,
  output logic [15:0] O_BIT_BRANCH_TARGET,
  output logic [7:0] O_BIT_MASK,
  output logic O_BIT_SET,
  output logic O_CARRY_WE,
  output logic O_CARRY_VAL
);

  // Control states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_DONE
  } oag_state_t;

  oag_state_t state_r; // Current state
  oag_req_t req_r; // Latched request, bytes in instruction order
  oag_res_t res_nxt; // Combinational result
  oag_res_t res_r; // Registered result
  logic [7:0] tested_r; // Tested byte read back
  logic [7:0] mask; // Bit mask
  logic tbit; // Tested bit
  logic match; // Bit matches polarity
  logic set_pol; // Set vs clear
  logic [8:0] lo_sum; // Low sum with carry
  logic [15:0] effective_address; // Operand address
  logic [15:0] tested_byte_address; // Byte-two address for bit test
  // Decode source: the live request on the start edge, so the result is
  // ready together with done; the latched copy takes over after idle
  oag_req_t src;
  // Byte under test: the answer itself on its edge, the kept copy after
  logic [7:0] test_data;
  logic res_load; // Result register load strobe

  // Sign-extend and add, wrapping 16 bits
  function automatic logic [15:0] oag_rel(input logic [15:0] base, input logic [7:0] off);
    oag_rel = base + {{8{off[7]}}, off};
  endfunction : oag_rel

  // Decode source selection
  assign src = (state_r == ST_IDLE) ? I_REQ : req_r;
  // Reading the answer directly avoids a stale bit on the load edge
  assign test_data = (state_r == ST_FETCH) ? I_RD_DATA : tested_r;
  // Results load on the taken start and again on the read answer
  assign res_load = (state_r == ST_IDLE && I_START) || (state_r == ST_FETCH && I_RD_VALID);

  oag_bit_unit u_bit (
    .i_opcode(src.opcode),
    .i_data(test_data),
    .o_mask(mask),
    .o_bit(tbit),
    .o_match(match),
    .o_set(set_pol)
  );

  // Sequencer
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          // Bit test needs its byte before deciding; others finish next cycle
          if (I_START) begin
            state_r <= (I_REQ.mode == OAG_BTB) ? ST_FETCH : ST_DONE;
          end
        end
        ST_FETCH: begin
          if (I_RD_VALID) begin
            state_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Request latch
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      req_r <= '0;
    end else if (state_r == ST_IDLE && I_START) begin
      req_r <= I_REQ;
    end
  end

  // Tested byte capture
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      tested_r <= 8'h00;
    end else if (state_r == ST_FETCH && I_RD_VALID) begin
      tested_r <= I_RD_DATA;
    end
  end

  // Address and PC arithmetic, every sum wrapping at 16 bits
  always_comb begin
    res_nxt = '0;
    // Index plus second byte; the 8-bit offset form redoes it below
    lo_sum = 9'(src.index_x) + 9'(src.byte2);
    effective_address = {OAG_ZERO_PAGE, src.byte1};
    tested_byte_address = {OAG_ZERO_PAGE, src.byte1};
    // Two-byte instructions are the common case
    res_nxt.next_pc = src.pc + OAG_LEN_2;
    unique case (src.mode)
      OAG_IMM: begin
        // Operand is the byte after the opcode
        effective_address = src.pc + OAG_LEN_1;
        res_nxt.next_pc = src.pc + OAG_LEN_2;
      end
      OAG_DIR: begin
        // Page zero only
        effective_address = {OAG_ZERO_PAGE, src.byte1};
      end
      OAG_EXT: begin
        // First byte is the high half
        effective_address = {src.byte1, src.byte2};
        res_nxt.next_pc = src.pc + OAG_LEN_3;
      end
      OAG_IX: begin
        // One-byte instruction, index alone
        effective_address = {OAG_ZERO_PAGE, src.index_x};
        res_nxt.next_pc = src.pc + OAG_LEN_1;
      end
      OAG_IX1: begin
        // Carry out of the byte sum becomes the high byte
        lo_sum = 9'(src.index_x) + 9'(src.byte1);
        effective_address = {7'h00, lo_sum};
      end
      OAG_IX2: begin
        // Low carry ripples into the first offset byte
        effective_address = {src.byte1 + 8'(lo_sum[8]), lo_sum[7:0]};
        res_nxt.next_pc = src.pc + OAG_LEN_3;
      end
      OAG_REL: begin
        // Taken branch: PC+2 plus signed offset, else fall through
        res_nxt.next_pc = src.cond_true ?
          oag_rel(src.pc + OAG_LEN_2, src.byte1) : src.pc + OAG_LEN_2;
        effective_address = res_nxt.next_pc;
      end
      OAG_BSC: begin
        // Page zero address, opcode picks the bit and its sense
        effective_address = {OAG_ZERO_PAGE, src.byte1};
        res_nxt.bit_mask = mask;
        res_nxt.bit_set = set_pol;
      end
      OAG_BTB: begin
        // Target always formed, taken only on a polarity match
        effective_address = tested_byte_address;
        res_nxt.bit_branch_target = oag_rel(src.pc + OAG_LEN_3, src.byte2);
        res_nxt.next_pc = match ? res_nxt.bit_branch_target
                                : src.pc + OAG_LEN_3;
        res_nxt.bit_mask = mask;
        // Carry follows the tested bit whether or not the branch is taken
        res_nxt.carry_we = 1'b1;
        res_nxt.carry_val = tbit;
      end
      default: begin
        // Unused mode codes give a harmless zero address
        effective_address = 16'h0000;
      end
    endcase
    res_nxt.addr_hi = effective_address[15:8];
    res_nxt.addr_lo = effective_address[7:0];
  end

  // Result register; loads on the taken start and again on the read answer, then holds
  // so the outputs stay put while idle
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      res_r <= '0;
    end else if (res_load) begin
      res_r <= res_nxt;
    end
  end

  // Bus read of the tested byte; only after both bytes were latched
  assign O_RD_REQ = (state_r == ST_FETCH);
  assign O_BUSY = (state_r != ST_IDLE);
  assign O_DONE = (state_r == ST_DONE);
  assign O_ADDR_HI = (state_r == ST_FETCH) ? OAG_ZERO_PAGE : res_r.addr_hi;
  assign O_ADDR_LO = (state_r == ST_FETCH) ? req_r.byte1 : res_r.addr_lo;
  assign O_NEXT_PC = res_r.next_pc;
  assign O_BIT_BRANCH_TARGET = res_r.bit_branch_target;
  assign O_BIT_MASK = res_r.bit_mask;
  assign O_BIT_SET = res_r.bit_set;
  assign O_CARRY_WE = O_DONE & res_r.carry_we;
  assign O_CARRY_VAL = res_r.carry_val;

  // Assertions
  a_ext_pc_adv: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    O_DONE && req_r.mode == OAG_EXT |-> O_NEXT_PC == req_r.pc + 16'h0003)
    else $error("extended next pc wrong");
  a_dir_zero_hi: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    O_DONE && req_r.mode == OAG_DIR |-> O_ADDR_HI == 8'h00 && O_ADDR_LO == req_r.byte1)
    else $error("direct address wrong");
  a_ix_no_off: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    O_DONE && req_r.mode == OAG_IX |-> O_ADDR_LO == req_r.index_x
      && O_NEXT_PC == req_r.pc + 16'h0001)
    else $error("indexed no offset wrong");
  a_ix1_carry: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    O_DONE && req_r.mode == OAG_IX1 |->
      {O_ADDR_HI, O_ADDR_LO} == 16'(req_r.index_x) + 16'(req_r.byte1))
    else $error("indexed 8-bit sum wrong");
  a_ix2_sum: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    O_DONE && req_r.mode == OAG_IX2 |->
      {O_ADDR_HI, O_ADDR_LO} == {req_r.byte1, req_r.byte2} + 16'(req_r.index_x))
    else $error("indexed 16-bit sum wrong");
  a_imm_addr: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    O_DONE && req_r.mode == OAG_IMM |->
      {O_ADDR_HI, O_ADDR_LO} == req_r.pc + 16'h0001 && O_NEXT_PC == req_r.pc + 16'h0002)
    else $error("immediate wrong");
  a_rel_fall: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    O_DONE && req_r.mode == OAG_REL && !req_r.cond_true |->
      O_NEXT_PC == req_r.pc + 16'h0002)
    else $error("relative fall through wrong");
  a_bsc_page: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    O_DONE && req_r.mode == OAG_BSC |-> O_ADDR_HI == 8'h00
      && $onehot(O_BIT_MASK) && O_NEXT_PC == req_r.pc + 16'h0002)
    else $error("bit set clear wrong");
  a_btb_branch: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    O_DONE && req_r.mode == OAG_BTB |->
      O_NEXT_PC == (match ? O_BIT_BRANCH_TARGET : req_r.pc + 16'h0003))
    else $error("bit branch pc wrong");
  a_btb_carry: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    O_DONE && req_r.mode == OAG_BTB |-> O_CARRY_WE && O_CARRY_VAL == tbit)
    else $error("carry not copied");
  a_ext_addr: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    O_DONE && req_r.mode == OAG_EXT |-> {O_ADDR_HI, O_ADDR_LO} == {req_r.byte1, req_r.byte2})
    else $error("extended address wrong");
  a_ix_hi_zero: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    O_DONE && req_r.mode == OAG_IX |-> O_ADDR_HI == 8'h00)
    else $error("indexed high byte not zero");
  a_rel_taken: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    O_DONE && req_r.mode == OAG_REL && req_r.cond_true |->
      O_NEXT_PC == req_r.pc + 16'h0002 + {{8{req_r.byte1[7]}}, req_r.byte1})
    else $error("relative taken target wrong");
  a_bsc_mask: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    O_DONE && req_r.mode == OAG_BSC |->
      O_BIT_MASK == (8'h01 << req_r.opcode[OAG_BITNUM_LSB +: 3])
      && O_BIT_SET == !req_r.opcode[OAG_POL_BIT])
    else $error("bit set clear mask wrong");
  a_btb_target: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    O_DONE && req_r.mode == OAG_BTB |->
      O_BIT_BRANCH_TARGET == req_r.pc + 16'h0003 + {{8{req_r.byte2[7]}}, req_r.byte2})
    else $error("bit branch target wrong");
  a_rd_req_page: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    O_RD_REQ |-> req_r.mode == OAG_BTB && O_ADDR_HI == 8'h00)
    else $error("tested byte read outside page zero");
  a_carry_src_bit: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    O_DONE && req_r.mode == OAG_BTB |->
      O_CARRY_VAL == tested_r[req_r.opcode[OAG_BITNUM_LSB +: 3]])
    else $error("carry not the tested bit");
  a_carry_only_btb: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    O_CARRY_WE |-> O_DONE && req_r.mode == OAG_BTB)
    else $error("carry written outside bit test");
  a_done_pulse: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    O_DONE |=> !O_DONE)
    else $error("done longer than one cycle");
  a_fetch_order: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    I_START && !O_BUSY && I_REQ.mode == OAG_BTB |=> O_RD_REQ
      && O_ADDR_LO == $past(I_REQ.byte1))
    else $error("tested byte fetch wrong");

  c_btb_taken: cover property (@(posedge I_REF_CLK) O_DONE && req_r.mode == OAG_BTB && match);
  c_rel_taken: cover property (@(posedge I_REF_CLK) O_DONE && req_r.mode == OAG_REL
    && req_r.cond_true);
  c_ix2_carry: cover property (@(posedge I_REF_CLK) O_DONE && req_r.mode == OAG_IX2
    && lo_sum[8]);
  c_ix1_carry: cover property (@(posedge I_REF_CLK) O_DONE && req_r.mode == OAG_IX1
    && O_ADDR_HI == 8'h01);
  c_btb_miss: cover property (@(posedge I_REF_CLK) O_DONE && req_r.mode == OAG_BTB && !match);

endmodule : oag_core

// ==== oag_pkg.sv ====
// Functional notes
// - Immediate: address PC+1, PC advances two
// - Direct: high zero, low from byte two
// - Extended: two bytes high then low, PC+3
// - Indexed no offset: X low, PC+1
// - Indexed 8-bit: X plus byte, carry high
// - Indexed 16-bit: carry into high byte, PC+3
// - Relative: PC+2 plus signed offset if taken
// - Bit set/clear: direct byte, modify one bit
// - Bit test branch: PC+3 plus offset on match
// - Tested bit copied into carry always
package oag_pkg;

  // Addressing modes
  typedef enum logic [3:0] {
    OAG_IMM,
    OAG_DIR,
    OAG_EXT,
    OAG_IX,
    OAG_IX1,
    OAG_IX2,
    OAG_REL,
    OAG_BSC,
    OAG_BTB
  } oag_mode_t;

  // Instruction lengths in bytes
  localparam logic [15:0] OAG_LEN_1 = 16'h0001;
  localparam logic [15:0] OAG_LEN_2 = 16'h0002;
  localparam logic [15:0] OAG_LEN_3 = 16'h0003;
  // Zero page high byte
  localparam logic [7:0] OAG_ZERO_PAGE = 8'h00;
  // Bit number field position in the opcode
  localparam int OAG_BITNUM_LSB = 1;
  // Polarity bit position in the opcode (0 = branch if set)
  localparam int OAG_POL_BIT = 0;

  // Decode request
  typedef struct packed {
    oag_mode_t mode;
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [7:0] index_x;
    logic [15:0] pc;
    logic cond_true;
  } oag_req_t;

  // Decode result
  typedef struct packed {
    logic [7:0] addr_hi;
    logic [7:0] addr_lo;
    logic [15:0] next_pc;
    logic [15:0] bit_branch_target;
    logic [7:0] bit_mask;
    logic bit_set;
    logic carry_we;
    logic carry_val;
  } oag_res_t;

endpackage : oag_pkg

// ==== oag_bit_unit.sv ====
`timescale 1ns/1ps
// Bit select, mask and test-and-branch decision
module oag_bit_unit
  import oag_pkg::*;
(
  input wire logic [7:0] i_opcode,
  input wire logic [7:0] i_data,
  output logic [7:0] o_mask,
  output logic o_bit,
  output logic o_match,
  output logic o_set
);
  logic [2:0] bit_num; // Bit number from opcode
  always_comb begin
    bit_num = i_opcode[OAG_BITNUM_LSB +: 3];
    o_mask = 8'h01 << bit_num;
    o_bit = i_data[bit_num];
    // Even opcode: branch/set when bit set; odd: when clear
    o_set = ~i_opcode[OAG_POL_BIT];
    o_match = (o_bit == o_set);
  end
endmodule : oag_bit_unit

// ==== tb_cpu_operand_address_generator.sv ====
`timescale 1ns/1ps
// Self-checking bench for the operand address generator
module tb_cpu_operand_address_generator;
  import oag_pkg::*;

  logic i_ref_clk = 1'b0; // 200 MHz core clock
  logic i_rst_b = 1'b0; // Sync reset, active low
  logic i_start = 1'b0; // Start pulse
  oag_req_t req = '0; // Instruction under decode
  logic [7:0] rd_data = 8'h00; // Tested byte from memory
  logic rd_valid = 1'b0; // Read answer strobe
  logic busy, done, rd_req, bit_set, carry_we, carry_val;
  logic [7:0] addr_hi, addr_lo, bit_mask;
  logic [15:0] next_pc, br_tgt;
  int fail_count = 0; // Mismatches seen
  int check_count = 0; // Comparisons made

  // Clock, half period 2.5 ns
  always #2.5 i_ref_clk = ~i_ref_clk;

  oag_core u_dut (
    .I_REF_CLK(i_ref_clk), .I_RST_B(i_rst_b), .I_START(i_start), .I_REQ(req),
    .I_RD_DATA(rd_data), .I_RD_VALID(rd_valid), .O_BUSY(busy), .O_DONE(done),
    .O_RD_REQ(rd_req), .O_ADDR_HI(addr_hi), .O_ADDR_LO(addr_lo), .O_NEXT_PC(next_pc),
    .O_BIT_BRANCH_TARGET(br_tgt), .O_BIT_MASK(bit_mask), .O_BIT_SET(bit_set),
    .O_CARRY_WE(carry_we), .O_CARRY_VAL(carry_val)
  );

  // Single comparison point, case equality so unknowns fail
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Verdict, reached from the main flow or the watchdog
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // One decode; returns in the cycle where the done pulse stands
  task automatic op_chk(input oag_mode_t m, input logic [7:0] op, b1, b2, x,
                        input logic [15:0] pc, input logic c, input logic [7:0] rd,
                        input logic [15:0] ea, npc);
    int n;
    @(posedge i_ref_clk);
    #1;
    // Done must have dropped after its single cycle
    check({15'h0, done}, 16'h0000);
    req = '{mode: m, opcode: op, byte1: b1, byte2: b2, index_x: x, pc: pc, cond_true: c};
    i_start = 1'b1;
    @(posedge i_ref_clk);
    #1;
    i_start = 1'b0;
    if (m == OAG_BTB) begin
      check({15'h0, rd_req}, 16'h0001);
      check({addr_hi, addr_lo}, {8'h00, b1});
      // Start while busy must be ignored without trace
      req.mode = OAG_DIR;
      i_start = 1'b1;
      @(posedge i_ref_clk);
      #1;
      i_start = 1'b0;
      @(posedge i_ref_clk);
      #1;
      // Slow answer, then the line no longer shows the byte
      rd_data = rd;
      rd_valid = 1'b1;
      @(posedge i_ref_clk);
      #1;
      rd_valid = 1'b0;
      rd_data = ~rd;
    end
    n = 0;
    // Bounded wait for completion
    while (done !== 1'b1 && n < 20) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    check({15'h0, done}, 16'h0001);
    check({15'h0, carry_we}, {15'h0, m == OAG_BTB});
    if (m != OAG_BTB) begin
      check({addr_hi, addr_lo}, ea);
    end
    check(next_pc, npc);
  endtask : op_chk

  // Outputs idle at zero out of reset
  task automatic t_reset();
    check({busy, done, rd_req, carry_we, 12'h000}, 16'h0000);
    check({addr_hi, addr_lo}, 16'h0000);
    check(next_pc, 16'h0000);
  endtask : t_reset

  // Plain address modes, wrap cases included
  task automatic t_addr_modes();
    op_chk(OAG_IMM, 8'hA6, 8'h12, 8'h34, 8'h00, 16'hFFFF, 1'b0, 8'h00, 16'h0000, 16'h0001);
    op_chk(OAG_IMM, 8'hA6, 8'h12, 8'h34, 8'h00, 16'h1234, 1'b0, 8'h00, 16'h1235, 16'h1236);
    op_chk(OAG_DIR, 8'hB6, 8'hFF, 8'h34, 8'h77, 16'h0200, 1'b0, 8'h00, 16'h00FF, 16'h0202);
    op_chk(OAG_EXT, 8'hC6, 8'hFF, 8'hFE, 8'h00, 16'hFFFE, 1'b0, 8'h00, 16'hFFFE, 16'h0001);
    op_chk(OAG_IX, 8'hF6, 8'h33, 8'h44, 8'hA5, 16'h0300, 1'b0, 8'h00, 16'h00A5, 16'h0301);
    op_chk(OAG_IX1, 8'hE6, 8'hFF, 8'h00, 8'hFF, 16'h0400, 1'b0, 8'h00, 16'h01FE, 16'h0402);
    op_chk(OAG_IX1, 8'hE6, 8'h20, 8'h00, 8'h10, 16'h0400, 1'b0, 8'h00, 16'h0030, 16'h0402);
    op_chk(OAG_IX2, 8'hD6, 8'hFF, 8'h80, 8'h80, 16'h0500, 1'b0, 8'h00, 16'h0000, 16'h0503);
    op_chk(OAG_IX2, 8'hD6, 8'h12, 8'hF0, 8'h20, 16'h0500, 1'b0, 8'h00, 16'h1310, 16'h0503);
  endtask : t_addr_modes

  // Relative branch taken and not taken, both offset signs
  task automatic t_rel();
    op_chk(OAG_REL, 8'h20, 8'h7F, 8'h00, 8'h00, 16'h0100, 1'b1, 8'h00, 16'h0181, 16'h0181);
    op_chk(OAG_REL, 8'h20, 8'h7F, 8'h00, 8'h00, 16'h0100, 1'b0, 8'h00, 16'h0102, 16'h0102);
    op_chk(OAG_REL, 8'h20, 8'h80, 8'h00, 8'h00, 16'h0100, 1'b1, 8'h00, 16'h0082, 16'h0082);
    op_chk(OAG_REL, 8'h20, 8'h20, 8'h00, 8'h00, 16'hFFF0, 1'b1, 8'h00, 16'h0012, 16'h0012);
  endtask : t_rel

  // Every bit number with set and clear
  task automatic t_bsc();
    logic [7:0] op;
    for (int b = 0; b < 8; b++) begin
      for (int p = 0; p < 2; p++) begin
        op = {4'h1, b[2:0], p[0]};
        op_chk(OAG_BSC, op, 8'h40 + b[7:0], 8'h00, 8'h00, 16'h0600, 1'b0, 8'h00,
               16'h0040 + b[15:0], 16'h0602);
        check({8'h00, bit_mask}, {8'h00, 8'h01 << b});
        check({15'h0, bit_set}, {15'h0, ~p[0]});
      end
    end
  endtask : t_bsc

  // Every bit number, both polarities, match and miss
  task automatic t_btb();
    logic [7:0] op, off;
    logic t, hit;
    logic [15:0] tg;
    for (int b = 0; b < 8; b++) begin
      for (int p = 0; p < 2; p++) begin
        op = {4'h0, b[2:0], p[0]};
        off = p[0] ? 8'h80 : 8'h7F;
        t = 1'(8'h5A >> b);
        hit = p[0] ? ~t : t;
        tg = 16'h0703 + {{8{off[7]}}, off};
        op_chk(OAG_BTB, op, 8'h30 + b[7:0], off, 8'h00, 16'h0700, 1'b0, 8'h5A,
               16'h0000, hit ? tg : 16'h0703);
        check({15'h0, carry_val}, {15'h0, t});
        // Target is formed whether or not the branch is taken
        check(br_tgt, tg);
      end
    end
  endtask : t_btb

  // Main sequence
  initial begin
    repeat (6) @(posedge i_ref_clk);
    #1;
    t_reset();
    i_rst_b = 1'b1;
    t_addr_modes();
    t_rel();
    t_bsc();
    t_btb();
    tally_and_finish();
  end

  // Watchdog, well beyond the 144 cycles the tests need
  initial begin
    repeat (3000) @(posedge i_ref_clk);
    fail_count++;
    tally_and_finish();
  end

endmodule : tb_cpu_operand_address_generator
